/* File: logic/irpc_top.sv */
`include "irpc_consts.svh"
`default_nettype none

module irpc_top #(
  parameter int NUM_SRC   = `IRPC_NUM_SRC,
  parameter int NUM_LINES = `IRPC_NUM_LINES
) (
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  input  wire logic                        narrow_io_flag,
  input  wire logic                        wide_cycle_sense_n,
  input  wire logic                        bus_mode_strap,
  input  wire logic [NUM_SRC-1:0]          irq_status,
  input  wire logic [NUM_SRC-1:0]          irq_enable,
  input  wire logic [`IRPC_SEL_W-1:0]      irq_line_sel,
  input  wire logic                        function_soft_reset,
  input  wire logic                        core_soft_reset,
  input  wire logic                        function_enable,
  input  wire logic                        sleep_pin_shared,
  input  wire logic [`IRPC_CODEC_W-1:0]    external_codec_select,
  input  wire logic                        legacy_sleep_bit,
  input  wire logic                        partial_sleep_enable,
  output logic                             byte_mode_8,
  output logic                             irq_pending,
  output logic [NUM_LINES-1:0]             irq_output_lines,
  output logic                             request_ready_line,
  output logic                             local_bus_mode,
  output irpc_pkg::irpc_reset_t            resets,
  output irpc_pkg::irpc_power_t            power,
  output logic                             modem_sleep_out_n,
  output irpc_pkg::irpc_pwr_state_t        power_state
);

  // ---------------------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------------------
  logic       rst_n;
  logic [2:0] pins_s;
  logic       wide_s;
  logic       sleep_s;
  logic       strap_s;

  // asynchronous assert, release after two edges
  irpc_sync #(.W(1)) u_rst_sync (
    .core_clk (core_clk),
    .rst_n    (resetn),
    .d        (1'b1),
    .q        (rst_n)
  );

  // pins come from outside the clock domain
  irpc_sync #(.W(3)) u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({wide_cycle_sense_n, sleep_pin_shared, bus_mode_strap}),
    .q        (pins_s)
  );

  assign wide_s  = pins_s[2];
  assign sleep_s = pins_s[1];
  assign strap_s = pins_s[0];

  // ---------------------------------------------------------------------------
  // interrupt merging
  // ---------------------------------------------------------------------------
  logic [NUM_SRC-1:0] masked;

  // per-source gating; clearing is done in the status owner
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_mask
    assign masked[i] = irq_status[i] & irq_enable[i];
  end

  // one-hot select of the output line
  function automatic logic [NUM_LINES-1:0] line_onehot(
    input logic [`IRPC_SEL_W-1:0] sel,
    input logic                   level
  );
    logic [NUM_LINES-1:0] v;
    v = '0;
    for (int k = 0; k < NUM_LINES; k++) begin
      if (sel == k[`IRPC_SEL_W-1:0]) begin
        v[k] = level;
      end
    end
    return v;
  endfunction : line_onehot

  // ---------------------------------------------------------------------------
  // state update
  // ---------------------------------------------------------------------------
  irpc_pkg::irpc_state_t s_q;
  irpc_pkg::irpc_state_t s_d;
  logic                  pin_sleep;
  logic                  boot_hit;

  // pin only means sleep when an external codec is fitted
  assign pin_sleep = sleep_s && (external_codec_select != `IRPC_CODEC_NONE);
  assign boot_hit  = !s_q.booted && (s_q.boot_cnt == `IRPC_BOOT_SAMPLE);

  // next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    // boot sequence: wait for synchronisers to flush before strap capture
    if (!s_q.booted) begin
      s_d.boot_cnt = s_q.boot_cnt + `IRPC_BOOT_W'(1);
    end
    if (boot_hit) begin
      s_d.booted         = 1'b1;
      s_d.local_bus_mode = strap_s;
    end
    s_d.fsr_seen = function_soft_reset;
    // mode sample only from hardware reset, EEPROM load from hardware reset or function reset
    s_d.rst.mode_sample = boot_hit;
    s_d.rst.eeprom_load = boot_hit
                          || (s_q.booted && function_soft_reset && !s_q.fsr_seen);
    // levels follow the host bits, so release only when the host clears them
    s_d.rst.func  = !s_q.booted || function_soft_reset;
    s_d.rst.setup = !s_q.booted || function_soft_reset;
    s_d.rst.core  = !s_q.booted || function_soft_reset || core_soft_reset;
    s_d.req_ready = s_q.booted && !function_soft_reset;
    // data port width
    s_d.byte_mode = narrow_io_flag || wide_s;
    // no master enable: merged level depends on per-source enables alone
    s_d.irq       = |masked;
    s_d.irq_lines = line_onehot(irq_line_sel, |masked);
    // power state; function_enable deliberately not consulted
    if (pin_sleep) begin
      s_d.pwr = irpc_pkg::PWR_PIN_DOWN;
    end else if (legacy_sleep_bit) begin
      s_d.pwr = irpc_pkg::PWR_ALL_DOWN;
    end else if (partial_sleep_enable) begin
      s_d.pwr = irpc_pkg::PWR_TX_DOWN;
    end else begin
      s_d.pwr = irpc_pkg::PWR_AWAKE;
    end
    case (s_d.pwr)
      irpc_pkg::PWR_AWAKE: begin
        s_d.power = '{core_on: 1'b1, tx_on: 1'b1, rx_on: 1'b1, link_on: 1'b1};
      end
      irpc_pkg::PWR_TX_DOWN: begin
        s_d.power = '{core_on: 1'b1, tx_on: 1'b0, rx_on: 1'b1, link_on: 1'b1};
      end
      irpc_pkg::PWR_ALL_DOWN: begin
        s_d.power = '{core_on: 1'b1, tx_on: 1'b0, rx_on: 1'b0, link_on: 1'b0};
      end
      irpc_pkg::PWR_PIN_DOWN: begin
        s_d.power = '{core_on: 1'b0, tx_on: 1'b0, rx_on: 1'b0, link_on: 1'b0};
      end
      default: begin
        s_d.power = '0;
      end
    endcase
    s_d.modem_n = (s_d.pwr != irpc_pkg::PWR_PIN_DOWN);
  end

  // func, core and setup resets held active until the boot sample has been taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q                 <= '0;
      s_q.rst.func        <= 1'b1;
      s_q.rst.core        <= 1'b1;
      s_q.rst.setup       <= 1'b1;
      s_q.pwr             <= irpc_pkg::PWR_AWAKE;
      s_q.power           <= '1;
      s_q.modem_n         <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------------------
  assign byte_mode_8        = s_q.byte_mode;
  assign irq_pending        = s_q.irq;
  assign irq_output_lines   = s_q.irq_lines;
  assign request_ready_line = s_q.req_ready;
  assign local_bus_mode     = s_q.local_bus_mode;
  assign resets             = s_q.rst;
  assign power              = s_q.power;
  assign modem_sleep_out_n  = s_q.modem_n;
  assign power_state        = s_q.pwr;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_byte_mode;
    (narrow_io_flag || wide_s) |=> byte_mode_8;
  endproperty
  a_byte_mode: assert property (p_byte_mode)
    else $error("8-bit mode not entered");

  property p_irq_line;
    (|(irq_status & irq_enable)) ##1 $stable(irq_line_sel)
      |-> irq_pending && (irq_output_lines == line_onehot(irq_line_sel, 1'b1));
  endproperty
  a_irq_line: assert property (p_irq_line)
    else $error("enabled source did not reach interrupt line");

  property p_no_master;
    (irq_enable == '0)[*2] |-> !irq_pending && (irq_output_lines == '0);
  endproperty
  a_no_master: assert property (p_no_master)
    else $error("interrupt raised with every source disabled");

  // tied to the boot counter, so the release edge itself cannot start a short window
  property p_boot;
    !s_q.booted && (s_q.boot_cnt == `IRPC_BOOT_SAMPLE)
      |=> resets.mode_sample && resets.eeprom_load && (local_bus_mode == $past(strap_s));
  endproperty
  a_boot: assert property (p_boot)
    else $error("hardware reset did not sample mode and load EEPROM");

  property p_func_reset;
    s_q.booted && $rose(function_soft_reset)
      |=> resets.eeprom_load && !resets.mode_sample && resets.func ##1 !resets.eeprom_load;
  endproperty
  a_func_reset: assert property (p_func_reset)
    else $error("function reset pulse wrong");

  property p_req_ready;
    s_q.booted && $fell(function_soft_reset) |=> request_ready_line;
  endproperty
  a_req_ready: assert property (p_req_ready)
    else $error("request line not raised after function reset");

  property p_req_low;
    function_soft_reset[*2] |-> !request_ready_line;
  endproperty
  a_req_low: assert property (p_req_low)
    else $error("request line high during function reset");

  property p_core_reset;
    s_q.booted && core_soft_reset && !function_soft_reset
      |=> resets.core && !resets.setup && !resets.eeprom_load && !resets.mode_sample;
  endproperty
  a_core_reset: assert property (p_core_reset)
    else $error("core reset touched setup registers or EEPROM");

  property p_pin_gate;
    sleep_s && (external_codec_select == `IRPC_CODEC_NONE)
      |=> modem_sleep_out_n && power.core_on;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("sleep pin honoured without external codec");

  property p_pin_down;
    pin_sleep |=> !modem_sleep_out_n && (power == '0);
  endproperty
  a_pin_down: assert property (p_pin_down)
    else $error("sleep pin did not power down everything");

  property p_awake;
    !pin_sleep && !legacy_sleep_bit && !partial_sleep_enable |=> (power == '1);
  endproperty
  a_awake: assert property (p_awake)
    else $error("not fully awake with sleep bits clear");

  property p_tx_only;
    !pin_sleep && !legacy_sleep_bit && partial_sleep_enable
      |=> !power.tx_on && power.rx_on && power.link_on;
  endproperty
  a_tx_only: assert property (p_tx_only)
    else $error("partial sleep wrong");

  property p_legacy;
    !pin_sleep && legacy_sleep_bit |=> !power.tx_on && !power.rx_on && !power.link_on;
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("legacy sleep bit did not win");

  property p_fen_ignored;
    $changed(function_enable) && $stable(pin_sleep) && $stable(legacy_sleep_bit)
      && $stable(partial_sleep_enable) && $past(power_state) == power_state
      |=> $stable(power_state);
  endproperty
  a_fen_ignored: assert property (p_fen_ignored)
    else $error("function enable changed power state");

endmodule : irpc_top

`default_nettype wire

/* File: logic/irpc_consts.svh */
`ifndef IRPC_CONSTS_SVH
`define IRPC_CONSTS_SVH

// ---------------------------------------------------------------------------
// sizes
// ---------------------------------------------------------------------------
`define IRPC_NUM_SRC      8
`define IRPC_NUM_LINES    4
`define IRPC_SEL_W        2
`define IRPC_CODEC_W      2
`define IRPC_SYNC_STAGES  2

// ---------------------------------------------------------------------------
// encodings and timing counts
// ---------------------------------------------------------------------------
`define IRPC_CODEC_NONE   2'h0
`define IRPC_BOOT_W       2
`define IRPC_BOOT_SAMPLE  2'h2

`endif

/* File: logic/irpc_pkg.sv */
`include "irpc_consts.svh"
`default_nettype none

package irpc_pkg;

  // ---------------------------------------------------------------------------
  // power state and carriers
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_TX_DOWN,
    PWR_ALL_DOWN,
    PWR_PIN_DOWN
  } irpc_pwr_state_t;

  // per-domain power enables, 1 = powered
  typedef struct packed {
    logic core_on;
    logic tx_on;
    logic rx_on;
    logic link_on;
  } irpc_power_t;

  // reset fan-out to the controller, all active high
  typedef struct packed {
    logic func;
    logic core;
    logic setup;
    logic eeprom_load;
    logic mode_sample;
  } irpc_reset_t;

  // whole state of the control block
  typedef struct packed {
    logic [`IRPC_BOOT_W-1:0]    boot_cnt;
    logic                       booted;
    logic                       local_bus_mode;
    logic                       fsr_seen;
    logic                       byte_mode;
    logic                       irq;
    logic [`IRPC_NUM_LINES-1:0] irq_lines;
    logic                       req_ready;
    irpc_pwr_state_t            pwr;
    irpc_power_t                power;
    logic                       modem_n;
    irpc_reset_t                rst;
  } irpc_state_t;

endpackage : irpc_pkg

`default_nettype wire

/* File: logic/irpc_sync.sv */
`include "irpc_consts.svh"
`default_nettype none

module irpc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ---------------------------------------------------------------------------
  // two-stage synchroniser, first stage read only by the second
  // ---------------------------------------------------------------------------
  logic [`IRPC_SYNC_STAGES-1:0][W-1:0] stage_q;

  // constant reset value only; also serves as the reset release chain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[0], d};
    end
  end

  assign q = stage_q[`IRPC_SYNC_STAGES-1];

endmodule : irpc_sync

`default_nettype wire

/* File: test/irpc_host_model.sv */
`default_nettype none

// ---------------------------------------------------------------------------
// host cpu and board pins, set at time zero and then driven at the falling edge
// ---------------------------------------------------------------------------
module irpc_host_model (
  input  wire logic       core_clk,
  output var  logic       narrow_io_flag,
  output var  logic       wide_cycle_sense_n,
  output var  logic       bus_mode_strap,
  output var  logic [7:0] irq_status,
  output var  logic [7:0] irq_enable,
  output var  logic [1:0] irq_line_sel,
  output var  logic       function_soft_reset,
  output var  logic       core_soft_reset,
  output var  logic       function_enable,
  output var  logic       sleep_pin_shared,
  output var  logic [1:0] external_codec_select,
  output var  logic       legacy_sleep_bit,
  output var  logic       partial_sleep_enable
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet host at time zero, strap picks local bus mode
  // the status power-down bit is never written, it has no wire here
  initial begin
    {narrow_io_flag, wide_cycle_sense_n, function_soft_reset, core_soft_reset} = 4'h0;
    {irq_status, irq_enable, irq_line_sel, function_enable} = 19'h0;
    {sleep_pin_shared, external_codec_select, legacy_sleep_bit} = 4'h0;
    partial_sleep_enable = 1'b0;
    bus_mode_strap       = 1'b1;
  end

  task automatic set_ctrl(input logic nio, input logic sense, input logic fres,
                          input logic cres, input logic fen);
    @(negedge core_clk);
    {narrow_io_flag, wide_cycle_sense_n, function_soft_reset} = {nio, sense, fres};
    {core_soft_reset, function_enable}                        = {cres, fen};
  endtask : set_ctrl

  task automatic set_irq(input logic [7:0] st, input logic [7:0] en, input logic [1:0] sel);
    @(negedge core_clk);
    {irq_status, irq_enable, irq_line_sel} = {st, en, sel};
  endtask : set_irq

  task automatic set_power(input logic pin, input logic [1:0] codec, input logic legacy,
                           input logic partial);
    @(negedge core_clk);
    {sleep_pin_shared, external_codec_select} = {pin, codec};
    {legacy_sleep_bit, partial_sleep_enable}  = {legacy, partial};
  endtask : set_power
endmodule : irpc_host_model

`default_nettype wire

/* File: test/interrupt_reset_power_control_tb_top.sv */
`default_nettype none

module interrupt_reset_power_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // clock, reset, wiring
  // ---------------------------------------------------------------------------
  logic                      core_clk = 1'b0;
  logic                      resetn   = 1'b0;
  logic                      nio, sense, strap, fres, cres, fen, pin, legacy, partial;
  logic [7:0]                st, en;
  logic [1:0]                sel, codec;
  logic                      byte_mode_8, irq_pending, request_ready_line, local_bus_mode;
  logic                      modem_sleep_out_n;
  logic [3:0]                irq_output_lines;
  irpc_pkg::irpc_reset_t     resets;
  irpc_pkg::irpc_power_t     power;
  irpc_pkg::irpc_pwr_state_t power_state;
  int                        fail_count, samples_checked, ee_cnt, ms_cnt;

  always #4 core_clk = ~core_clk;

  irpc_host_model irpc_host_model_inst (.core_clk(core_clk), .narrow_io_flag(nio),
    .wide_cycle_sense_n(sense), .bus_mode_strap(strap), .irq_status(st), .irq_enable(en),
    .irq_line_sel(sel), .function_soft_reset(fres), .core_soft_reset(cres),
    .function_enable(fen), .sleep_pin_shared(pin), .external_codec_select(codec),
    .legacy_sleep_bit(legacy), .partial_sleep_enable(partial));

  irpc_top irpc_top_inst (.core_clk(core_clk), .resetn(resetn), .narrow_io_flag(nio),
    .wide_cycle_sense_n(sense), .bus_mode_strap(strap), .irq_status(st), .irq_enable(en),
    .irq_line_sel(sel), .function_soft_reset(fres), .core_soft_reset(cres),
    .function_enable(fen), .sleep_pin_shared(pin), .external_codec_select(codec),
    .legacy_sleep_bit(legacy), .partial_sleep_enable(partial), .byte_mode_8(byte_mode_8),
    .irq_pending(irq_pending), .irq_output_lines(irq_output_lines),
    .request_ready_line(request_ready_line), .local_bus_mode(local_bus_mode),
    .resets(resets), .power(power), .modem_sleep_out_n(modem_sleep_out_n),
    .power_state(power_state));

  // one-cycle pulses are counted mid-cycle so no sampling point can miss them
  always @(negedge core_clk) begin
    if (resets.eeprom_load === 1'b1) ee_cnt++;
    if (resets.mode_sample === 1'b1) ms_cnt++;
  end

  // ---------------------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_vec

  task automatic complete_run;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // pin changes need three edges, so four falling edges covers every path
  task automatic settle;
    repeat (4) @(negedge core_clk);
  endtask : settle

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_boot;
    int n;
    for (n = 0; n < 40 && request_ready_line !== 1'b1; n++) @(negedge core_clk);
    chk_bit(request_ready_line, 1'b1, "ready after boot");
    chk_bit(local_bus_mode, 1'b1, "strap captured");
    chk_vec(8'(ee_cnt), 8'h01, "boot eeprom load");
    chk_vec(8'(ms_cnt), 8'h01, "boot mode sample");
    chk_vec(8'(power), 8'h0F, "boot power");
  endtask : t_boot

  task automatic t_byte;
    int i;
    for (i = 0; i < 4; i++) begin
      irpc_host_model_inst.set_ctrl(i[0], i[1], 1'b0, 1'b0, 1'b0);
      settle();
      chk_bit(byte_mode_8, i[0] | i[1], "byte mode");
    end
  endtask : t_byte

  task automatic t_irq;
    int i;
    logic [7:0] one;
    for (i = 0; i < 8; i++) begin
      one = 8'h01 << i;
      irpc_host_model_inst.set_ctrl(1'b0, 1'b0, 1'b0, 1'b0, i[0]);
      irpc_host_model_inst.set_irq(one, ~one, i[1:0]);
      settle();
      chk_bit(irq_pending, 1'b0, "masked source");
      chk_vec(8'(irq_output_lines), 8'h00, "masked lines");
      irpc_host_model_inst.set_irq(one, one, i[1:0]);
      settle();
      chk_bit(irq_pending, 1'b1, "enabled source");
      chk_vec(8'(irq_output_lines), 8'h01 << i[1:0], "line select");
    end
    irpc_host_model_inst.set_irq(8'h00, 8'hFF, 2'h0);
    settle();
    chk_bit(irq_pending, 1'b0, "status cleared");
  endtask : t_irq

  task automatic t_resets;
    irpc_host_model_inst.set_ctrl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    settle();
    chk_bit(request_ready_line, 1'b0, "ready low in reset");
    chk_vec(8'(resets[4:2]), 8'h07, "function reset fan");
    chk_vec(8'(ee_cnt), 8'h02, "function eeprom load");
    chk_vec(8'(ms_cnt), 8'h01, "no resample");
    irpc_host_model_inst.set_ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle();
    chk_bit(request_ready_line, 1'b1, "ready raised");
    irpc_host_model_inst.set_ctrl(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    settle();
    chk_vec(8'(resets[4:2]), 8'h02, "core reset keeps setup");
    chk_vec(8'(ee_cnt * 16 + ms_cnt), 8'h21, "core no load");
    irpc_host_model_inst.set_ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle();
    chk_bit(resets.core, 1'b0, "core reset released");
  endtask : t_resets

  // walks every pin/bit mix with codec 0 or 2; some steps enter sleep rather than wake from the last
  task automatic t_power;
    int i;
    logic       hon;
    logic [7:0] ep, es;
    for (i = 0; i < 16; i++) begin
      irpc_host_model_inst.set_power(i[3], {i[2], 1'b0}, i[1], i[0]);
      hon = i[3] & i[2];
      ep  = hon ? 8'h00 : i[1] ? 8'h08 : i[0] ? 8'h0B : 8'h0F;
      es  = hon ? 8'h03 : i[1] ? 8'h02 : i[0] ? 8'h01 : 8'h00;
      settle();
      chk_vec(8'(power), ep, "power enables");
      chk_vec(8'(power_state), es, "power state");
      chk_bit(modem_sleep_out_n, ~hon, "modem sleep");
    end
  endtask : t_power

  // wake paths: pin release, partial sleep cleared, legacy bit cleared; odd codec codes too
  task automatic t_wake;
    int         i;
    logic [4:0] stim [8];
    logic [7:0] ep   [8];
    logic [7:0] es   [8];
    stim = '{5'h14, 5'h04, 5'h0D, 5'h0C, 5'h0E, 5'h0C, 5'h1F, 5'h00};
    ep   = '{8'h00, 8'h0F, 8'h0B, 8'h0F, 8'h08, 8'h0F, 8'h00, 8'h0F};
    es   = '{8'h03, 8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03, 8'h00};
    for (i = 0; i < 8; i++) begin
      irpc_host_model_inst.set_power(stim[i][4], stim[i][3:2], stim[i][1], stim[i][0]);
      settle();
      chk_vec(8'(power), ep[i], "wake power");
      chk_vec(8'(power_state), es[i], "wake state");
      chk_bit(modem_sleep_out_n, ~(stim[i][4] & (|stim[i][3:2])), "wake modem");
    end
  endtask : t_wake

  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    fail_count      = 0;
    samples_checked = 0;
    ee_cnt          = 0;
    ms_cnt          = 0;
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
    t_boot();
    t_byte();
    t_irq();
    t_resets();
    t_power();
    t_wake();
    complete_run();
  end

  // about 300 cycles are needed; this cuts a hang well past that
  initial begin
    #40000;
    fail_count++;
    complete_run();
  end
endmodule : interrupt_reset_power_control_tb_top

`default_nettype wire
